// ==== logic/cam_main_timer.sv ====
/*
 * Counter array main timer: 16-bit up-counter with selectable timebase,
 * coherent two-byte read through a snapshot, overflow flag and interrupt
 * request, idle suspend, and the lost-overflow quirk on control-register
 * read-modify-write.
 * Assumes a synchronous special function register port: one-cycle read and
 * write strobes, read data valid the cycle after the read strobe, and a
 * level from the CPU marking the execution phase of a read-modify-write
 * aimed at the control register.
 */
`timescale 1ns/1ps

// Contract
// - The count is one 16-bit up-counter seen by software as a low and a high byte.
// - Reading the low byte latches the high byte so the next high read is coherent.
// - Reading either byte never disturbs counting.
// - The select field picks system clock by 12, by 4, timer 0 overflow or system clock.
// - Select 011 counts falling edges of the external input, at most a quarter clock rate.
// - Select 101 counts the external oscillator divided by 8 after synchronisation.
// - Wrapping from all ones to zero sets the overflow flag.
// - The interrupt request follows the overflow flag only while its enable is set.
// - Entering the service routine does not clear the flag; software clears it.
// - With the idle control clear the counter keeps running during CPU idle.
// - A wrap during a control-register read-modify-write does not set the flag.
// - Software may set the flag, which then acts like a hardware-set flag.
// - The 16-bit count is supplied to the six capture/compare modules.
module cam_main_timer
   import cam_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic [7:0]  i_sfr_addr,
   input  wire logic        i_sfr_wr,
   input  wire logic        i_sfr_rd,
   input  wire logic [7:0]  i_sfr_wdata,
   input  wire logic        i_rmw_ctrl_exec,
   input  wire logic        i_cpu_idle,
   input  wire logic        i_t0_ovf,
   input  wire logic        i_ext_count_in,
   input  wire logic        i_ext_osc,
   output logic      [7:0]  o_sfr_rdata,
   output logic      [15:0] o_count,
   output logic             o_irq
);

   typedef struct packed {
      logic [15:0] count;
      logic [7:0]  snap;
      logic [7:0]  mode;
      logic        ovf;
      logic        run;
      logic [7:0]  rdata;
      logic        irq;
   } cam_state_s;

   cam_state_s st_reg;
   cam_state_s st_next;

   cam_tick_if tk ();

   cam_timebase u_timebase (
      .i_clock        (i_clock),
      .i_reset        (i_reset),
      .i_t0_ovf       (i_t0_ovf),
      .i_ext_count_in (i_ext_count_in),
      .i_ext_osc      (i_ext_osc),
      .tk             (tk)
   );

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   logic rd_low;
   logic rd_high;
   logic wr_low;
   logic wr_high;
   logic wr_mode;
   logic wr_ctrl;
   logic idle_hold;
   logic advance;
   logic wrap;

   assign tk.sel = st_reg.mode[CAM_MODE_SEL_LSB +: 3];

   always_comb begin
      st_next   = st_reg;
      rd_low    = i_sfr_rd & hit(i_sfr_addr, CAM_OFS_LOW);
      rd_high   = i_sfr_rd & hit(i_sfr_addr, CAM_OFS_HIGH);
      wr_low    = i_sfr_wr & hit(i_sfr_addr, CAM_OFS_LOW);
      wr_high   = i_sfr_wr & hit(i_sfr_addr, CAM_OFS_HIGH);
      wr_mode   = i_sfr_wr & hit(i_sfr_addr, CAM_OFS_MODE);
      wr_ctrl   = i_sfr_wr & hit(i_sfr_addr, CAM_OFS_CTRL);

      // Idle only stalls the count when software asked for it.
      idle_hold = st_reg.mode[CAM_MODE_IDLE_BIT] & i_cpu_idle;
      advance   = st_reg.run & tk.tick & ~idle_hold;
      wrap      = advance & (st_reg.count == CAM_COUNT_MAX);

      // Reads play no part here, so counting is never disturbed by them.
      if (advance) begin
         st_next.count = st_reg.count + 16'h0001;
      end
      // A software write to a count byte wins over a tick in the same cycle.
      if (wr_low) begin
         st_next.count[7:0] = i_sfr_wdata;
      end
      if (wr_high) begin
         st_next.count[15:8] = i_sfr_wdata;
      end

      if (wr_mode) begin
         st_next.mode = i_sfr_wdata;
      end

      // The flag only ever falls through a software write.
      if (wr_ctrl) begin
         st_next.ovf = i_sfr_wdata[CAM_CTRL_OVF_BIT];
         st_next.run = i_sfr_wdata[CAM_CTRL_RUN_BIT];
      end
      // A wrap beats a clearing write, except during a control-register
      // read-modify-write, where the write-back drops the hardware set.
      if (wrap && !i_rmw_ctrl_exec) begin
         st_next.ovf = 1'b1;
      end else if (wrap && i_rmw_ctrl_exec && !wr_ctrl) begin
         st_next.ovf = st_reg.ovf;
      end

      st_next.irq = st_next.ovf & st_next.mode[CAM_MODE_IRQEN_BIT];

      // Read data stands one cycle after the strobe; unmapped reads give zero.
      st_next.rdata = 8'h00;
      if (rd_low) begin
         st_next.rdata = st_reg.count[7:0];
         st_next.snap  = st_reg.count[15:8];
      end else if (rd_high) begin
         st_next.rdata = st_reg.snap;
      end else if (i_sfr_rd && hit(i_sfr_addr, CAM_OFS_MODE)) begin
         st_next.rdata = st_reg.mode;
      end else if (i_sfr_rd && hit(i_sfr_addr, CAM_OFS_CTRL)) begin
         st_next.rdata = 8'h00;
         st_next.rdata[CAM_CTRL_OVF_BIT] = st_reg.ovf;
         st_next.rdata[CAM_CTRL_RUN_BIT] = st_reg.run;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         st_reg       <= '0;
         st_reg.count <= CAM_COUNT_RST;
         st_reg.mode  <= CAM_MODE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_sfr_rdata = st_reg.rdata;
   // One shared count bus feeds all six capture/compare modules.
   assign o_count     = st_reg.count;
   // Recognition by the CPU also needs its own global and array enables.
   assign o_irq       = st_reg.irq;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   sequence s_read_low;
      rd_low;
   endsequence

   sequence s_read_high;
      rd_high;
   endsequence

   sequence s_clean_tick;
      advance && !wr_low && !wr_high;
   endsequence

   a_coherent_pair: assert property (s_read_low ##1 s_read_high
      |=> o_sfr_rdata == $past(st_reg.count[15:8], 2))
      else $error("high byte read after low read is not the latched value");
   a_read_no_stall: assert property (i_sfr_rd ##0 s_clean_tick
      |=> st_reg.count == $past(st_reg.count) + 16'h0001)
      else $error("count did not advance during a read");
   a_wrap_sets_flag: assert property (wrap && !i_rmw_ctrl_exec |=> st_reg.ovf)
      else $error("wrap did not set the overflow flag");
   a_rmw_loses_wrap: assert property (wrap && i_rmw_ctrl_exec && !wr_ctrl
      && !st_reg.ovf |=> !st_reg.ovf)
      else $error("wrap during read-modify-write set the flag");
   a_irq_follows_flag: assert property (o_irq == (st_reg.ovf
      && st_reg.mode[CAM_MODE_IRQEN_BIT]))
      else $error("interrupt request does not match flag and enable");
   a_flag_sticky: assert property (st_reg.ovf && !wr_ctrl |=> st_reg.ovf)
      else $error("overflow flag cleared without a software write");
   a_sw_set_irq: assert property (wr_ctrl && i_sfr_wdata[CAM_CTRL_OVF_BIT]
      && st_reg.mode[CAM_MODE_IRQEN_BIT] && !wr_mode |=> o_irq)
      else $error("software-set flag raised no request");
   a_stop_holds: assert property (!st_reg.run && !wr_low && !wr_high
      |=> $stable(st_reg.count))
      else $error("count moved while stopped");
   a_idle_pause: assert property (idle_hold && !wr_low && !wr_high
      |=> $stable(st_reg.count))
      else $error("count moved during suspended idle");
   a_idle_runs: assert property (i_cpu_idle && !st_reg.mode[CAM_MODE_IDLE_BIT]
      ##0 s_clean_tick |=> st_reg.count == $past(st_reg.count) + 16'h0001)
      else $error("count stalled during idle with suspend off");

   // The register view is what software trusts for the lost-wrap workaround,
   // so the snapshot, the wrap value and the control image are all pinned down.
   a_low_latches_snap: assert property (s_read_low |=>
      st_reg.snap == $past(st_reg.count[15:8]))
      else $error("low byte read did not latch the high byte");
   a_read_keeps_count: assert property (i_sfr_rd && !advance && !wr_low && !wr_high |=>
      $stable(st_reg.count))
      else $error("a read moved the count by itself");
   a_wrap_to_zero: assert property (wrap && !wr_low && !wr_high |=>
      st_reg.count == 16'h0000)
      else $error("wrap did not bring the count to zero");
   a_run_follows_write: assert property (wr_ctrl |=>
      st_reg.run == $past(i_sfr_wdata[CAM_CTRL_RUN_BIT]))
      else $error("run control did not take the written value");
   a_ctrl_read_image: assert property (i_sfr_rd && hit(i_sfr_addr, CAM_OFS_CTRL) |=>
      o_sfr_rdata == {$past(st_reg.ovf), $past(st_reg.run), 6'h00})
      else $error("control read does not show flag and run");

endmodule : cam_main_timer

// ==== logic/cam_pkg.sv ====
/*
 * Shared constants for the counter array main timer: register offsets,
 * field positions, reset values, timebase select codes and divider counts.
 * Assumes an 8-bit special function register port with 8-bit offsets.
 */
package cam_pkg;

   // Register offsets on the special function register port.
   localparam logic [7:0] CAM_OFS_LOW  = 8'h00;
   localparam logic [7:0] CAM_OFS_HIGH = 8'h01;
   localparam logic [7:0] CAM_OFS_MODE = 8'h02;
   localparam logic [7:0] CAM_OFS_CTRL = 8'h03;

   // Field positions in the mode register.
   localparam int CAM_MODE_IDLE_BIT  = 7;
   localparam int CAM_MODE_SEL_LSB   = 1;
   localparam int CAM_MODE_IRQEN_BIT = 0;

   // Field positions in the control register.
   localparam int CAM_CTRL_OVF_BIT = 7;
   localparam int CAM_CTRL_RUN_BIT = 6;

   // Values after reset, and the count value that wraps to zero.
   localparam logic [7:0]  CAM_MODE_RST  = 8'h00;
   localparam logic [15:0] CAM_COUNT_RST = 16'h0000;
   localparam logic [15:0] CAM_COUNT_MAX = 16'hffff;

   // Timebase select codes.
   localparam logic [2:0] CAM_SEL_DIV12  = 3'h0;
   localparam logic [2:0] CAM_SEL_DIV4   = 3'h1;
   localparam logic [2:0] CAM_SEL_T0OVF  = 3'h2;
   localparam logic [2:0] CAM_SEL_EXTIN  = 3'h3;
   localparam logic [2:0] CAM_SEL_SYSCLK = 3'h4;
   localparam logic [2:0] CAM_SEL_OSC8   = 3'h5;

   // Divider counts in system clock cycles or oscillator edges.
   localparam int CAM_SYS_DIV12 = 12;
   localparam int CAM_SYS_DIV4  = 4;
   localparam int CAM_OSC_DIV   = 8;
   localparam logic [3:0] CAM_PRE_LAST  = 4'(CAM_SYS_DIV12 - 1);
   localparam logic [1:0] CAM_DIV4_LAST = 2'(CAM_SYS_DIV4 - 1);
   localparam logic [2:0] CAM_OSC_LAST  = 3'(CAM_OSC_DIV - 1);

endpackage : cam_pkg

// ==== logic/cam_tick_if.sv ====
/*
 * Carries the timebase select code to the tick generator and the tick back.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface cam_tick_if;
   logic [2:0] sel;
   logic       tick;
   modport src (input sel, output tick);
   modport snk (output sel, input tick);
endinterface : cam_tick_if

// ==== logic/cam_timebase.sv ====
/*
 * Timebase tick generator: turns the selected count source into one-cycle
 * ticks in the system clock domain.
 * Assumes the timer 0 overflow and external count input are synchronous to
 * i_clock; the external oscillator is not and is synchronised here.
 */
`timescale 1ns/1ps
module cam_timebase
   import cam_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_reset,
   input  wire logic i_t0_ovf,
   input  wire logic i_ext_count_in,
   input  wire logic i_ext_osc,
   cam_tick_if.src   tk
);

   typedef struct packed {
      logic [3:0] pre;
      logic       ext_q;
      logic       ext_prev;
      logic       osc_s1;
      logic       osc_s2;
      logic       osc_q;
      logic [2:0] osc_div;
      logic       tick;
   } cam_tb_state_s;

   cam_tb_state_s st_reg;
   cam_tb_state_s st_next;
   logic          osc_rise;

   always_comb begin
      st_next          = st_reg;
      st_next.pre      = (st_reg.pre == CAM_PRE_LAST) ? 4'h0 : st_reg.pre + 4'h1;
      st_next.ext_q    = i_ext_count_in;
      st_next.ext_prev = st_reg.ext_q;
      // Two flops before anything looks at the oscillator level.
      st_next.osc_s1   = i_ext_osc;
      st_next.osc_s2   = st_reg.osc_s1;
      st_next.osc_q    = st_reg.osc_s2;
      osc_rise         = st_reg.osc_s2 & ~st_reg.osc_q;
      if (osc_rise) begin
         st_next.osc_div = st_reg.osc_div + 3'h1;
      end
      case (tk.sel)
         CAM_SEL_DIV12:  st_next.tick = (st_reg.pre == CAM_PRE_LAST);
         CAM_SEL_DIV4:   st_next.tick = (st_reg.pre[1:0] == CAM_DIV4_LAST);
         CAM_SEL_T0OVF:  st_next.tick = i_t0_ovf;
         CAM_SEL_EXTIN:  st_next.tick = st_reg.ext_prev & ~st_reg.ext_q;
         CAM_SEL_SYSCLK: st_next.tick = 1'b1;
         CAM_SEL_OSC8:   st_next.tick = osc_rise & (st_reg.osc_div == CAM_OSC_LAST);
         default:        st_next.tick = 1'b0;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tk.tick = st_reg.tick;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   a_sysclk_every_cycle: assert property (tk.sel == CAM_SEL_SYSCLK |=> tk.tick)
      else $error("system clock timebase missed a tick");
   a_div4_period: assert property ((tk.tick && tk.sel == CAM_SEL_DIV4)
      ##1 (!tk.tick && tk.sel == CAM_SEL_DIV4) [*3] |=> tk.tick)
      else $error("divide by four tick spacing wrong");
   a_ext_fall_tick: assert property (tk.sel == CAM_SEL_EXTIN && st_reg.ext_prev
      && !st_reg.ext_q |=> tk.tick)
      else $error("external falling edge not counted");
   a_osc_div_tick: assert property (tk.sel == CAM_SEL_OSC8 && osc_rise
      && st_reg.osc_div == CAM_OSC_LAST |=> tk.tick)
      else $error("oscillator divide by eight tick missing");

endmodule : cam_timebase

// ==== tb/cam_main_timer_bench.sv ====
/*
 * Self-checking bench for the counter array main timer.
 * Assumes the design top with its register port, one 200 MHz clock and a
 * synchronous active-high reset; the bench drives every input itself.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module cam_main_timer_bench;
   import cam_pkg::*;
   typedef struct {logic [2:0] sel; logic [15:0] exp;} cam_row_s;
   logic        i_clock, i_reset, i_sfr_wr, i_sfr_rd, i_rmw_ctrl_exec, i_cpu_idle;
   logic        i_t0_ovf, i_ext_count_in, i_ext_osc;
   logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, d;
   logic [15:0] o_count, c, dl;
   logic        o_irq;
   logic [15:0] pre_cnt, post_cnt;
   logic        cpu_global_en, cpu_array_en;
   int          n_errors, num_checks, cyc, i;
   // The 96-cycle window spans whole periods of every stimulus, so counts are exact.
   cam_row_s rows [8] = '{'{3'h0, 16'h0008}, '{3'h1, 16'h0018}, '{3'h2, 16'h0020},
      '{3'h3, 16'h0018}, '{3'h4, 16'h0060}, '{3'h5, 16'h0006}, '{3'h6, 16'h0000},
      '{3'h7, 16'h0000}};
   cam_main_timer dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_sfr_addr(i_sfr_addr),
      .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
      .i_rmw_ctrl_exec(i_rmw_ctrl_exec), .i_cpu_idle(i_cpu_idle), .i_t0_ovf(i_t0_ovf),
      .i_ext_count_in(i_ext_count_in), .i_ext_osc(i_ext_osc), .o_sfr_rdata(o_sfr_rdata),
      .o_count(o_count), .o_irq(o_irq));
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   // Oscillator edges land on falling system clock edges, well clear of sampling.
   initial begin
      i_ext_osc = 1'b0;
      forever #5 i_ext_osc = ~i_ext_osc;
   end
   always @(posedge i_clock) begin
      #1;
      cyc = cyc + 1;
      i_t0_ovf = (cyc % 3 == 0);
      // One falling edge every four cycles, the fastest the input may go.
      i_ext_count_in = cyc[1];
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clock);
      #1;
      i_sfr_addr = a;
      i_sfr_wdata = v;
      i_sfr_wr = 1'b1;
      @(posedge i_clock);
      #1;
      i_sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [15:0] cn);
      @(posedge i_clock);
      #1;
      i_sfr_addr = a;
      i_sfr_rd = 1'b1;
      cn = o_count;
      @(posedge i_clock);
      #1;
      i_sfr_rd = 1'b0;
      v = o_sfr_rdata;
   endtask : rd
   // Low then high on consecutive cycles, the strobe held up between them.
   task automatic rd_pair(output logic [15:0] v);
      @(posedge i_clock);
      #1;
      i_sfr_addr = CAM_OFS_LOW;
      i_sfr_rd = 1'b1;
      @(posedge i_clock);
      #1;
      i_sfr_addr = CAM_OFS_HIGH;
      v[7:0] = o_sfr_rdata;
      @(posedge i_clock);
      #1;
      i_sfr_rd = 1'b0;
      v[15:8] = o_sfr_rdata;
   endtask : rd_pair
   task automatic meas(input int n, output logic [15:0] dv);
      logic [15:0] c0;
      @(posedge i_clock);
      #1;
      c0 = o_count;
      repeat (n) @(posedge i_clock);
      #1;
      dv = o_count - c0;
   endtask : meas
   task automatic wrap_from(input logic [7:0] lo);
      int k;
      wr(CAM_OFS_CTRL, 8'h00);
      wr(CAM_OFS_HIGH, 8'hff);
      wr(CAM_OFS_LOW, lo);
      wr(CAM_OFS_CTRL, 8'h40);
      for (k = 0; k < 300 && o_count !== 16'h0000; k++) begin
         @(posedge i_clock);
         #1;
      end
      if (k == 300) begin
         n_errors++;
         tally_and_finish();
      end
   endtask : wrap_from
   initial begin
      {i_sfr_wr, i_sfr_rd, i_rmw_ctrl_exec, i_cpu_idle, i_t0_ovf, i_ext_count_in} = '0;
      i_sfr_addr = 8'h00;
      i_sfr_wdata = 8'h00;
      cyc = 0;
      n_errors = 0;
      num_checks = 0;
      cpu_global_en = 1'b1;
      cpu_array_en = 1'b1;
      i_reset = 1'b1;
      repeat (12) @(posedge i_clock);
      #1;
      i_reset = 1'b0;
      `CHK("count after reset", CAM_COUNT_RST, o_count)
      `CHK("irq after reset", 1'b0, o_irq)
      for (i = 0; i < 5; i++) begin
         rd(8'(i), d, c);
         `CHK("register after reset", 8'h00, d)
      end
      wr(CAM_OFS_CTRL, 8'h40);
      foreach (rows[r]) begin
         wr(CAM_OFS_MODE, {4'h0, rows[r].sel, 1'b0});
         rd(CAM_OFS_MODE, d, c);
         `CHK("mode readback", {4'h0, rows[r].sel, 1'b0}, d)
         repeat (16) @(posedge i_clock);
         meas(96, dl);
         `CHK("ticks in window", rows[r].exp, dl)
      end
      wr(CAM_OFS_MODE, {4'h0, CAM_SEL_SYSCLK, 1'b0});
      wr(CAM_OFS_CTRL, 8'h00);
      meas(20, dl);
      `CHK("held while stopped", 16'h0000, dl)
      wr(CAM_OFS_HIGH, 8'h12);
      wr(CAM_OFS_LOW, 8'hfc);
      wr(CAM_OFS_CTRL, 8'h40);
      rd(CAM_OFS_LOW, d, c);
      `CHK("low byte read", c[7:0], d)
      repeat (6) @(posedge i_clock);
      rd(CAM_OFS_HIGH, d, dl);
      `CHK("high from snapshot", c[15:8], d)
      `CHK("live high moved on", 8'h13, o_count[15:8])
      meas(20, dl);
      `CHK("counting after reads", 16'h0014, dl)
      wr(CAM_OFS_CTRL, 8'h00);
      wr(CAM_OFS_HIGH, 8'h34);
      wr(CAM_OFS_LOW, 8'hfe);
      wr(CAM_OFS_CTRL, 8'h40);
      rd_pair(dl);
      `CHK("coherent pair across carry", 16'h34ff, dl)
      `CHK("live high after carry", 8'h35, o_count[15:8])
      rd(8'h07, d, c);
      `CHK("unmapped read", 8'h00, d)
      wrap_from(8'hf0);
      rd(CAM_OFS_CTRL, d, c);
      `CHK("flag after wrap", 8'hc0, d)
      `CHK("irq disabled", 1'b0, o_irq)
      wr(CAM_OFS_MODE, {4'h0, CAM_SEL_SYSCLK, 1'b1});
      @(posedge i_clock);
      #1;
      `CHK("irq enabled", 1'b1, o_irq)
      wr(CAM_OFS_CTRL, 8'h40);
      @(posedge i_clock);
      #1;
      `CHK("irq after clear", 1'b0, o_irq)
      wr(CAM_OFS_CTRL, 8'hc0);
      @(posedge i_clock);
      #1;
      `CHK("irq after software set", 1'b1, o_irq)
      wr(CAM_OFS_CTRL, 8'h40);
      i_rmw_ctrl_exec = 1'b1;
      wrap_from(8'he0);
      @(posedge i_clock);
      #1;
      i_rmw_ctrl_exec = 1'b0;
      rd(CAM_OFS_CTRL, d, c);
      `CHK("wrap lost in rmw", 8'h40, d)
      `CHK("no irq for lost wrap", 1'b0, o_irq)
      // Software guard: compare the high bytes read around the bit operation.
      wr(CAM_OFS_CTRL, 8'h00);
      wr(CAM_OFS_HIGH, 8'hff);
      wr(CAM_OFS_LOW, 8'hf0);
      wr(CAM_OFS_CTRL, 8'h40);
      cpu_global_en = 1'b0;
      rd_pair(pre_cnt);
      i_rmw_ctrl_exec = 1'b1;
      repeat (20) @(posedge i_clock);
      #1;
      i_rmw_ctrl_exec = 1'b0;
      rd_pair(post_cnt);
      `CHK("wrap lost again", 1'b0, o_irq)
      if (pre_cnt[15:8] == 8'hff && post_cnt[15:8] == 8'h00) begin
         wr(CAM_OFS_CTRL, 8'hc0);
      end
      cpu_global_en = 1'b1;
      rd(CAM_OFS_CTRL, d, c);
      `CHK("flag restored by software", 8'hc0, d)
      `CHK("request recognised", 1'b1, o_irq & cpu_global_en & cpu_array_en)
      i_cpu_idle = 1'b1;
      meas(20, dl);
      `CHK("runs in idle", 16'h0014, dl)
      wr(CAM_OFS_MODE, {1'b1, 3'h0, CAM_SEL_SYSCLK, 1'b0});
      meas(20, dl);
      `CHK("suspended in idle", 16'h0000, dl)
      i_cpu_idle = 1'b0;
      repeat (4) @(posedge i_clock);
      meas(20, dl);
      `CHK("resumes after idle", 16'h0014, dl)
      // A second reset in mid-run, with flag and request up, must clear them all.
      wr(CAM_OFS_MODE, {4'h0, CAM_SEL_SYSCLK, 1'b1});
      wr(CAM_OFS_CTRL, 8'hc0);
      @(posedge i_clock);
      #1;
      `CHK("irq before second reset", 1'b1, o_irq)
      i_reset = 1'b1;
      repeat (2) @(posedge i_clock);
      #1;
      i_reset = 1'b0;
      `CHK("count after second reset", CAM_COUNT_RST, o_count)
      `CHK("irq after second reset", 1'b0, o_irq)
      rd(CAM_OFS_MODE, d, c);
      `CHK("mode after second reset", CAM_MODE_RST, d)
      rd(CAM_OFS_CTRL, d, c);
      `CHK("control after second reset", 8'h00, d)
      meas(20, dl);
      `CHK("held after second reset", 16'h0000, dl)
      tally_and_finish();
   end
endmodule : cam_main_timer_bench
